// File: inc/serdes_regs_cfg.svh
/*
  Constants for the lane status, lock and link reset register group.
  Assumes byte-wide registers on a 12-bit register address.
*/
`ifndef SERDES_REGS_CFG_SVH
`define SERDES_REGS_CFG_SVH
`define ADDR_W          12
`define DATA_W          8
`define LANES           16
`define LANE_SEL_W      4
`define PHASE_W         8
`define PLLS            4
`define OFS_W           16
`define ADDR_CDR_PHASE  12'h239
`define ADDR_PLL_STATUS 12'h250
`define ADDR_LINK_RST   12'h253
`define ADDR_EXTERNAL_REFERENCE_PIN     12'h2B0
`define ADDR_CUR_2X     12'h2B1
`define ADDR_OFS_HOLD   12'h2CF
`define RST_CTL         8'h00
`define RD_UNMAPPED     8'h00
`define BIT_FUNC        0
`define LOST_LSB        0
`define LIVE_LSB        4
`define LIVE_MSB        7
`define LOST_MSB        3
`endif

// File: inc/serdes_regs_pkg.sv
/*
  Types for the lane status, lock and link reset register group.
  Assumes the constants header is on the include path.
*/
`include "serdes_regs_cfg.svh"
package serdes_regs_pkg;
  typedef logic [`PHASE_W-1:0] lane_word_t;
  typedef struct packed {
    lane_word_t [`LANES-1:0] lane;
  } lane_bus_t;
  typedef struct packed {
    logic [`OFS_W-1:0] ofs1;
    logic [`OFS_W-1:0] ofs0;
  } offset_pair_t;
endpackage

// File: design/serdes_status_link_reset_regs.sv
/*
  Byte-wide register group: lane recovery phase readout, lock status of
  four link PLLs, link digital reset, reference select, current doubler
  and offset update hold.
  Assumes the register port, phase, arrival and offset inputs are on
  i_core_clk; PLL lock inputs are asynchronous.
*/
`timescale 1ns/1ps
`include "serdes_regs_cfg.svh"

// Functional notes
// - Phase register reads the selected lane's present phase, all eight bits.
// - Phase read value is gray coded.
// - Upper status nibble shows live lock of each of four PLLs.
// - Lock-lost bit sets whenever its live lock bit is low; a PLL lock low for only one cycle never reaches it.
// - Lock-lost bit n covers lanes 4n to 4n+3.
// - Lock-lost bits are sticky and clear on write of one.
// - Link reset bit holds link receiver digital logic in reset.
// - Lane arrival captured only on first buffer release try after enable or after link reset clears.
// - Reference select bit switches converter to external reference pin.
// - Current doubler bit doubles analog output current.
// - Hold bit stops new offsets reaching converters.
// - Hold falling applies pending offsets to both converters together.
module serdes_status_link_reset_regs
  import serdes_regs_pkg::*;
(
  input  wire logic                   i_core_clk,             // Core clock
  input  wire logic                   i_nrst,                 // Async reset, low
  input  wire logic                   i_reg_wr,               // Register write strobe
  input  wire logic                   i_reg_rd,               // Register read strobe
  input  wire logic [`ADDR_W-1:0]     i_reg_addr,             // Register address
  input  wire logic [`DATA_W-1:0]     i_reg_wdata,            // Write data
  output logic      [`DATA_W-1:0]     o_reg_rdata,            // Read data, next cycle
  input  wire logic [`LANE_SEL_W-1:0] i_readout_lane_select,  // Lane for phase read
  input  wire lane_bus_t              i_clock_recovery_phase, // Binary phase per lane
  input  wire logic [`PLLS-1:0]       i_serdes_lock,          // PLL lock, async
  input  wire logic                   i_link_enable_bit,      // Link enable level
  input  wire logic                   i_ebuf_release_try,     // Release attempt pulse
  input  wire lane_bus_t              i_lane_arrival,         // Arrival per lane
  input  wire offset_pair_t           i_converter_offset_value, // Offset registers
  output lane_bus_t                   o_lane_arrival_capture, // Captured arrival
  output logic                        o_link_digital_reset,   // Link digital reset
  output logic                        o_external_reference_select, // Ext reference
  output logic                        o_output_current_doubler,    // Current 2x
  output offset_pair_t                o_applied_offset        // Offsets in use
);

  logic [`PLLS-1:0]    lock_s1_q;
  logic [`PLLS-1:0]    lock_s2_q;
  logic [`PLLS-1:0]    lock_s3_q;
  logic [`PLLS-1:0]    lock_live_q;
  logic [`PLLS-1:0]    lock_lost_q;
  logic [`PLLS-1:0]    lock_lost_d;
  logic [`DATA_W-1:0]  link_rst_q;
  logic [`DATA_W-1:0]  external_reference_pin_q;
  logic [`DATA_W-1:0]  cur2x_q;
  logic [`DATA_W-1:0]  hold_q;
  logic [`DATA_W-1:0]  rdata_d;
  logic                arrival_armed_q;
  logic                arrival_rearm;
  logic                arrival_take;
  lane_word_t          phase_bin;
  lane_word_t          phase_gray;
  logic                wr_status;

  // Selected lane phase and its gray form
  // lane phase select
  assign phase_bin  = i_clock_recovery_phase.lane[i_readout_lane_select];
  assign phase_gray = phase_bin ^ {1'h0, phase_bin[`PHASE_W-1:1]};

  // Lock synchronisers, three stages
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lock_s1_q <= '0;
      lock_s2_q <= '0;
      lock_s3_q <= '0;
    end else begin
      lock_s1_q <= i_serdes_lock;
      lock_s2_q <= lock_s1_q;
      lock_s3_q <= lock_s2_q;
    end
  end

  // Live lock follows once stages two and three agree
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lock_live_q <= '0;
    end else begin
      for (int i = 0; i < `PLLS; i++) begin
        if (lock_s2_q[i] == lock_s3_q[i]) begin
          lock_live_q[i] <= lock_s3_q[i];
        end
      end
    end
  end

  assign wr_status = i_reg_wr && (i_reg_addr == `ADDR_PLL_STATUS);

  // Sticky lock-lost bits, set beats clear
  always_comb begin
    lock_lost_d = lock_lost_q;
    if (wr_status) begin
      lock_lost_d = lock_lost_d & ~i_reg_wdata[`LOST_MSB:`LOST_LSB];
    end
    // set on low lock, bit n per PLL n
    lock_lost_d = lock_lost_d | ~lock_live_q;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lock_lost_q <= '0;
    end else begin
      lock_lost_q <= lock_lost_d;
    end
  end

  // Control registers, full byte kept
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      link_rst_q <= `RST_CTL;
      external_reference_pin_q   <= `RST_CTL;
      cur2x_q    <= `RST_CTL;
      hold_q     <= `RST_CTL;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `ADDR_LINK_RST: link_rst_q <= i_reg_wdata;
        `ADDR_EXTERNAL_REFERENCE_PIN:   external_reference_pin_q   <= i_reg_wdata;
        `ADDR_CUR_2X:   cur2x_q    <= i_reg_wdata;
        `ADDR_OFS_HOLD: hold_q     <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // Analog and link control outputs
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_link_digital_reset        <= 1'h0;
      o_external_reference_select <= 1'h0;
      o_output_current_doubler    <= 1'h0;
    end else begin
      o_link_digital_reset        <= link_rst_d_bit(link_rst_q, i_reg_wr, i_reg_addr,
                                                    i_reg_wdata, `ADDR_LINK_RST);
      o_external_reference_select <= link_rst_d_bit(external_reference_pin_q, i_reg_wr, i_reg_addr,
                                                    i_reg_wdata, `ADDR_EXTERNAL_REFERENCE_PIN);
      o_output_current_doubler    <= link_rst_d_bit(cur2x_q, i_reg_wr, i_reg_addr,
                                                    i_reg_wdata, `ADDR_CUR_2X);
    end
  end

  // Next functional bit of a control register
  function automatic logic link_rst_d_bit(
    input logic [`DATA_W-1:0] cur,
    input logic               wr,
    input logic [`ADDR_W-1:0] addr,
    input logic [`DATA_W-1:0] wdata,
    input logic [`ADDR_W-1:0] own
  );
    link_rst_d_bit = (wr && addr == own) ? wdata[`BIT_FUNC] : cur[`BIT_FUNC];
  endfunction

  // Offsets pass through unless held
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_applied_offset <= '0;
    end else if (!hold_q[`BIT_FUNC]) begin
      o_applied_offset <= i_converter_offset_value;
    end
  end

  // Arrival capture armed by disable or link reset
  assign arrival_rearm = !i_link_enable_bit || link_rst_q[`BIT_FUNC];
  assign arrival_take  = arrival_armed_q && !arrival_rearm && i_ebuf_release_try;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      arrival_armed_q <= 1'h1;
    end else if (arrival_rearm) begin
      arrival_armed_q <= 1'h1;
    end else if (arrival_take) begin
      arrival_armed_q <= 1'h0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_lane_arrival_capture <= '0;
    end else if (arrival_take) begin
      o_lane_arrival_capture <= i_lane_arrival;
    end
  end

  // Read multiplexer
  always_comb begin
    case (i_reg_addr)
      `ADDR_CDR_PHASE:  rdata_d = phase_gray;
      `ADDR_PLL_STATUS: rdata_d = {lock_live_q, lock_lost_q};
      `ADDR_LINK_RST:   rdata_d = link_rst_q;
      `ADDR_EXTERNAL_REFERENCE_PIN:     rdata_d = external_reference_pin_q;
      `ADDR_CUR_2X:     rdata_d = cur2x_q;
      `ADDR_OFS_HOLD:   rdata_d = hold_q;
      default:          rdata_d = `RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= `RD_UNMAPPED;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_d;
    end
  end

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_hold_release;
    hold_q[`BIT_FUNC] ##1 !hold_q[`BIT_FUNC];
  endsequence

  // Write to the link reset register
  sequence s_link_rst_write;
    i_reg_wr && i_reg_addr == `ADDR_LINK_RST;
  endsequence

  a_phase_read_gray: assert property (
    i_reg_rd && i_reg_addr == `ADDR_CDR_PHASE |=> o_reg_rdata == $past(phase_gray))
    else $error("phase read mismatch");

  a_gray_one_bit: assert property (
    $stable(i_readout_lane_select) && phase_bin == $past(phase_bin) + 8'h01
    |-> $countones(phase_gray ^ $past(phase_gray)) == 1)
    else $error("phase code not gray");

  a_live_lock_follow: assert property (
    lock_s2_q == lock_s3_q |=> lock_live_q == $past(lock_s3_q))
    else $error("live lock wrong");

  a_lost_on_low: assert property (
    (|(~lock_live_q)) |=> (lock_lost_q & ~$past(lock_live_q)) == ~$past(lock_live_q))
    else $error("lock lost not set");

  a_lost_readback: assert property (
    i_reg_rd && i_reg_addr == `ADDR_PLL_STATUS
    |=> o_reg_rdata == {$past(lock_live_q), $past(lock_lost_q)})
    else $error("pll status layout wrong");

  a_lost_sticky: assert property (
    !wr_status |=> (lock_lost_q & $past(lock_lost_q)) == $past(lock_lost_q))
    else $error("lock lost dropped");

  a_link_reset_out: assert property (
    s_link_rst_write
    |=> o_link_digital_reset == $past(i_reg_wdata[`BIT_FUNC])
    ##1 o_link_digital_reset == link_rst_q[`BIT_FUNC])
    else $error("link reset wrong");

  a_arrival_once: assert property (
    !arrival_armed_q && !arrival_rearm |=> $stable(o_lane_arrival_capture))
    else $error("arrival recaptured");

  a_external_reference_pin_sel: assert property (
    i_reg_wr && i_reg_addr == `ADDR_EXTERNAL_REFERENCE_PIN
    |=> o_external_reference_select == $past(i_reg_wdata[`BIT_FUNC]))
    else $error("reference select wrong");

  a_doubler_ctl: assert property (
    i_reg_wr && i_reg_addr == `ADDR_CUR_2X
    |=> o_output_current_doubler == $past(i_reg_wdata[`BIT_FUNC]))
    else $error("current doubler wrong");

  a_hold_keeps: assert property (
    hold_q[`BIT_FUNC] |=> $stable(o_applied_offset))
    else $error("offset moved while held");

  a_release_apply: assert property (
    s_hold_release |=> o_applied_offset == $past(i_converter_offset_value))
    else $error("offsets not applied on release");

  a_reserved_quiet: assert property (
    i_reg_wr && i_reg_addr == `ADDR_EXTERNAL_REFERENCE_PIN
    && i_reg_wdata[`BIT_FUNC] == external_reference_pin_q[`BIT_FUNC] |=> $stable(o_external_reference_select))
    else $error("reserved bit had effect");

  a_lost_clear: assert property (
    wr_status && (&lock_live_q)
    |=> (lock_lost_q & $past(i_reg_wdata[`LOST_MSB:`LOST_LSB])) == '0)
    else $error("lock lost not cleared");

  a_arrival_take: assert property (
    arrival_take |=> o_lane_arrival_capture == $past(i_lane_arrival))
    else $error("arrival not captured");

  a_offset_follow: assert property (
    !hold_q[`BIT_FUNC] |=> o_applied_offset == $past(i_converter_offset_value))
    else $error("offset not passed through");

  a_reserved_kept: assert property (
    i_reg_rd && i_reg_addr == `ADDR_EXTERNAL_REFERENCE_PIN |=> o_reg_rdata == $past(external_reference_pin_q))
    else $error("reserved bits not kept");

endmodule

// File: bench/tb.sv
/*
  Self-checking bench for the lane status, lock and link reset registers.
  Assumes the constants header and package are compiled first; the bench
  drives every input at the falling edge of a 100 MHz clock.
*/
`timescale 1ns/1ps
`include "serdes_regs_cfg.svh"
module tb
  import serdes_regs_pkg::*;
;
  logic                   i_core_clk = 1'b0;
  logic                   i_nrst     = 1'b0;
  logic                   i_reg_wr   = 1'b0;
  logic                   i_reg_rd   = 1'b0;
  logic [`ADDR_W-1:0]     i_reg_addr = '0;
  logic [`DATA_W-1:0]     i_reg_wdata = '0;
  logic [`DATA_W-1:0]     o_reg_rdata;
  logic [`LANE_SEL_W-1:0] i_readout_lane_select = '0;
  lane_bus_t              i_clock_recovery_phase = '0;
  logic [`PLLS-1:0]       i_serdes_lock = 4'hF;
  logic                   i_link_enable_bit = 1'b0;
  logic                   i_ebuf_release_try = 1'b0;
  lane_bus_t              i_lane_arrival = '0;
  offset_pair_t           i_converter_offset_value = '0;
  lane_bus_t              o_lane_arrival_capture;
  logic                   o_link_digital_reset;
  logic                   o_external_reference_select;
  logic                   o_output_current_doubler;
  offset_pair_t           o_applied_offset;
  int                     err_total = 0;
  int                     check_count = 0;
  localparam logic [127:0] ARR_A = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;

  // Free-running core clock
  always #5 i_core_clk = ~i_core_clk;

  serdes_status_link_reset_regs serdes_status_link_reset_regs_inst (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_readout_lane_select(i_readout_lane_select),
    .i_clock_recovery_phase(i_clock_recovery_phase), .i_serdes_lock(i_serdes_lock),
    .i_link_enable_bit(i_link_enable_bit), .i_ebuf_release_try(i_ebuf_release_try),
    .i_lane_arrival(i_lane_arrival), .i_converter_offset_value(i_converter_offset_value),
    .o_lane_arrival_capture(o_lane_arrival_capture),
    .o_link_digital_reset(o_link_digital_reset),
    .o_external_reference_select(o_external_reference_select),
    .o_output_current_doubler(o_output_current_doubler),
    .o_applied_offset(o_applied_offset));

  // Compare and count
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One register write, strobe for one cycle
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    @(negedge i_core_clk);
    i_reg_wr = 1'b1; i_reg_addr = a; i_reg_wdata = d;
    @(negedge i_core_clk);
    i_reg_wr = 1'b0;
  endtask

  // One register read, data compared the cycle after the strobe
  task automatic rd(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] e);
    @(negedge i_core_clk);
    i_reg_rd = 1'b1; i_reg_addr = a;
    @(negedge i_core_clk);
    i_reg_rd = 1'b0;
    chk(o_reg_rdata, e, "register read");
  endtask

  task automatic t_reset();
    chk({o_link_digital_reset, o_external_reference_select, o_output_current_doubler}, 0,
        "outputs after reset");
    chk(o_applied_offset, 0, "offset after reset");
    rd(`ADDR_LINK_RST, `RST_CTL); rd(`ADDR_EXTERNAL_REFERENCE_PIN, `RST_CTL);
    rd(`ADDR_CUR_2X, `RST_CTL); rd(`ADDR_OFS_HOLD, `RST_CTL);
    rd(12'h3FF, `RD_UNMAPPED);
    $display("test reset done");
  endtask

  task automatic t_phase();
    logic [7:0] b;
    for (int n = 0; n < `LANES; n++) i_clock_recovery_phase.lane[n] = 8'(n * 17 + 3);
    wr(`ADDR_CDR_PHASE, 8'hFF);
    for (int n = 0; n < `LANES; n += 5) begin
      b = 8'(n * 17 + 3);
      i_readout_lane_select = 4'(n);
      rd(`ADDR_CDR_PHASE, b ^ (b >> 1));
    end
    // Phase of lane 15 steps by one each cycle
    for (int k = 0; k < 4; k++) begin
      @(negedge i_core_clk);
      i_clock_recovery_phase.lane[15] = i_clock_recovery_phase.lane[15] + 8'h01;
    end
    b = 8'h06;
    rd(`ADDR_CDR_PHASE, b ^ (b >> 1));
    $display("test phase done");
  endtask

  task automatic t_lock();
    repeat (8) @(negedge i_core_clk);
    wr(`ADDR_PLL_STATUS, 8'h0F);
    rd(`ADDR_PLL_STATUS, 8'hF0);
    i_serdes_lock[2] = 1'b0;
    repeat (8) @(negedge i_core_clk);
    rd(`ADDR_PLL_STATUS, 8'hB4);
    wr(`ADDR_PLL_STATUS, 8'h04);
    rd(`ADDR_PLL_STATUS, 8'hB4);
    i_serdes_lock[2] = 1'b1;
    repeat (8) @(negedge i_core_clk);
    rd(`ADDR_PLL_STATUS, 8'hF4);
    wr(`ADDR_PLL_STATUS, 8'h0B);
    rd(`ADDR_PLL_STATUS, 8'hF4);
    wr(`ADDR_PLL_STATUS, 8'h04);
    rd(`ADDR_PLL_STATUS, 8'hF0);
    $display("test lock done");
  endtask

  task automatic try_pulse();
    @(negedge i_core_clk);
    i_ebuf_release_try = 1'b1;
    @(negedge i_core_clk);
    i_ebuf_release_try = 1'b0;
    @(negedge i_core_clk);
  endtask

  task automatic t_link();
    chk(o_lane_arrival_capture, 0, "capture after reset");
    i_link_enable_bit = 1'b1; i_lane_arrival = ARR_A;
    try_pulse();
    chk(o_lane_arrival_capture, ARR_A, "first capture");
    i_lane_arrival = ~ARR_A;
    try_pulse();
    chk(o_lane_arrival_capture, ARR_A, "later try ignored");
    i_link_enable_bit = 1'b0;
    wr(`ADDR_LINK_RST, 8'h01);
    i_link_enable_bit = 1'b1;
    @(negedge i_core_clk);
    chk(o_link_digital_reset, 1'b1, "link reset held");
    try_pulse();
    chk(o_lane_arrival_capture, ARR_A, "no capture in reset");
    wr(`ADDR_LINK_RST, 8'h00);
    @(negedge i_core_clk);
    chk(o_link_digital_reset, 1'b0, "link reset freed");
    try_pulse();
    chk(o_lane_arrival_capture, ~ARR_A, "capture after rearm");
    $display("test link done");
  endtask

  task automatic t_ctl();
    wr(`ADDR_EXTERNAL_REFERENCE_PIN, 8'hA5);
    @(negedge i_core_clk);
    chk(o_external_reference_select, 1'b1, "ext reference on");
    rd(`ADDR_EXTERNAL_REFERENCE_PIN, 8'hA5);
    wr(`ADDR_EXTERNAL_REFERENCE_PIN, 8'h81);
    @(negedge i_core_clk);
    chk(o_external_reference_select, 1'b1, "reserved bits only changed");
    rd(`ADDR_EXTERNAL_REFERENCE_PIN, 8'h81);
    wr(`ADDR_CUR_2X, 8'h01);
    @(negedge i_core_clk);
    chk(o_output_current_doubler, 1'b1, "doubler on");
    wr(`ADDR_CUR_2X, 8'hFE);
    @(negedge i_core_clk);
    chk(o_output_current_doubler, 1'b0, "reserved bits no effect");
    wr(`ADDR_EXTERNAL_REFERENCE_PIN, 8'h5A);
    @(negedge i_core_clk);
    chk(o_external_reference_select, 1'b0, "ext reference off");
    $display("test control done");
  endtask

  task automatic t_offset();
    i_converter_offset_value = 32'h1234ABCD;
    repeat (2) @(negedge i_core_clk);
    chk(o_applied_offset, 32'h1234ABCD, "offset follows");
    wr(`ADDR_OFS_HOLD, 8'h01);
    @(negedge i_core_clk);
    i_converter_offset_value = 32'h8765FEDC;
    repeat (4) @(negedge i_core_clk);
    chk(o_applied_offset, 32'h1234ABCD, "offset frozen");
    wr(`ADDR_OFS_HOLD, 8'h00);
    chk(o_applied_offset, 32'h1234ABCD, "still frozen");
    @(negedge i_core_clk);
    chk(o_applied_offset, 32'h8765FEDC, "both halves together");
    $display("test offset done");
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_nrst = 1'b1;
    t_reset();
    t_phase();
    t_lock();
    t_link();
    t_ctl();
    t_offset();
    final_report();
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge i_core_clk);
    err_total++;
    $display("wrong value at %0t: run limit reached", $time);
    final_report();
  end
endmodule
